// ==== can_mode_transition_control.sv ====
// Function
// RULE_01: Forcible reset code enters reset immediately.
// RULE_02: Normal reset: immediate receiving, waits transmit end.
// RULE_03: Reset request during bus-off skips recovery.
// RULE_04: Halt waits for current message end.
// RULE_05: Default recovery: halt accepted after recovery.
// RULE_06: Code 01: auto halt on bus-off entry.
// RULE_07: Code 10: auto halt after recovery ends.
// RULE_08: Code 11: halt request during bus-off immediate.
// RULE_09: Suspended transmit: idle, next end, or receiver.
// RULE_10: Dominant-stuck bus raises readable lock flag.
// RULE_11: Lock flag falling forces internal reset. The code does so only from ST_OPER and ignores it in ST_RESET and ST_HALT.
// RULE_12: Recessive bits after lock mean resolved.
// RULE_13: Lock flag 0 clear, 1 locked, reset 0.
// RULE_14: Clock select bit 0, reserved ignore writes.
// RULE_15: FIFO pointer writes advance, reads undefined.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module can_mode_transition_control
  import can_mode_pkg::*;
#(
  parameter int LOCK_LEN = can_mode_pkg::LOCK_CYCLES
) (
  // Clocking
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine status
  input wire logic receiving,
  input wire logic transmitting,
  input wire logic txSuspended,
  input wire logic busIdle,
  input wire logic txEnd,
  input wire logic rxEnd,
  input wire logic busOff,
  input wire logic recoveryDone,
  input wire logic busLevel,
  // Results
  output logic [3:0] channelState,
  output logic clockSource,
  output logic rxPtrAdvance,
  output logic txPtrAdvance,
  output logic irq
);
  import can_mode_pkg::*;

  chan_state_t state_reg, state_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] bom_reg, bom_next;
  logic haltReq_reg, haltReq_next;
  logic clkSel_reg, clkSel_next;
  logic [IRQ_W-1:0] irqEn_reg, irqEn_next;
  logic [7:0] rxPtr_reg, rxPtr_next, txPtr_reg, txPtr_next;
  logic [1:0] hold_reg, hold_next;
  logic busOffDly_reg;
  logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next, bresp_reg, bresp_next;
  logic locked, unlockPulse, wrFire, busOffEntry, msgDone, haltAsk;
  logic [IRQ_W-1:0] events, clrMask, status;

  bus_lock_detect #(.LOCK_LEN(LOCK_LEN)) lockDet (
    .clock(clock),
    .resetn(resetn),
    .enable(clockEnable),
    .busLevel(busLevel),
    .locked(locked), // [RULE_10] [RULE_13]
    .unlockPulse(unlockPulse)
  );

  // Write slave: address and data latched independently
  // Handshakes drop while frozen, else a beat would be taken and never latched
  assign s_axi_awready = clockEnable && !aw_reg && !b_reg;
  assign s_axi_wready = clockEnable && !w_reg && !b_reg;
  assign wrFire = clockEnable && aw_reg && w_reg && !b_reg;
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    b_next = b_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    bresp_next = bresp_reg;
    mode_next = mode_reg;
    bom_next = bom_reg;
    haltReq_next = haltReq_reg;
    clkSel_next = clkSel_reg;
    irqEn_next = irqEn_reg;
    rxPtr_next = rxPtr_reg;
    txPtr_next = txPtr_reg;
    clrMask = '0;
    rxPtrAdvance = 1'b0;
    txPtrAdvance = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wdata_next = s_axi_wdata;
    end
    if (wrFire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      b_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awaddr_reg)
        ADDR_CTRL: begin
          mode_next = wdata_reg[MODE_LSB+:2];
          bom_next = wdata_reg[BOM_LSB+:2];
          haltReq_next = wdata_reg[HALTREQ_BIT];
        end
        ADDR_CLKSEL: clkSel_next = wdata_reg[CLKSEL_BIT]; // [RULE_14]
        ADDR_RXFPC: begin
          rxPtr_next = rxPtr_reg + 8'h01; // [RULE_15]
          rxPtrAdvance = 1'b1;
        end
        ADDR_TXFPC: begin
          txPtr_next = txPtr_reg + 8'h01; // [RULE_15]
          txPtrAdvance = 1'b1;
        end
        ADDR_IRQEN: irqEn_next = wdata_reg[IRQ_W-1:0];
        ADDR_IRQCLR: clrMask = wdata_reg[IRQ_W-1:0];
        ADDR_STATUS, ADDR_ERRCAUSE, ADDR_FIFOPTR: ;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) b_next = 1'b0;
    // Halt request is consumed once the channel sits in halt
    if (state_reg == ST_HALT) haltReq_next = 1'b0;
  end

  // Read slave
  assign s_axi_arready = clockEnable && !r_reg;
  always_comb begin
    r_next = r_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      r_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_next = {27'h0, haltReq_reg, bom_reg, mode_reg};
        ADDR_STATUS: rdata_next = {28'h0, state_reg};
        ADDR_CLKSEL: rdata_next = {31'h0, clkSel_reg}; // [RULE_14]
        ADDR_RXFPC, ADDR_TXFPC: rdata_next = '0; // [RULE_15]
        ADDR_ERRCAUSE: rdata_next = {31'h0, locked}; // [RULE_13]
        ADDR_IRQEN: rdata_next = {28'h0, irqEn_reg};
        ADDR_IRQCLR: rdata_next = {28'h0, status};
        ADDR_FIFOPTR: rdata_next = {16'h0, txPtr_reg, rxPtr_reg};
        default: rresp_next = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      r_next = 1'b0;
    end
  end

  // Mode sequencer
  assign busOffEntry = busOff && !busOffDly_reg;
  assign msgDone = (receiving && rxEnd) || (transmitting && txEnd);
  // Mode-field halt and the request bit both count as a software halt
  assign haltAsk = haltReq_reg || (mode_reg == MODE_HALT);
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    case (state_reg)
      ST_OPER: begin
        if (unlockPulse) begin
          state_next = ST_INTRST; // [RULE_11]
          hold_next = 2'(RESET_HOLD_CYCLES);
        end else if (mode_reg == MODE_FORCE) begin
          state_next = ST_RESET; // [RULE_01]
        end else if (mode_reg == MODE_RESET) begin
          if (busOff) state_next = ST_RESET; // [RULE_03]
          else if (txSuspended) begin
            if (busIdle || txEnd || receiving) state_next = ST_RESET; // [RULE_09]
          end else if (!transmitting || txEnd) state_next = ST_RESET; // [RULE_02]
        end else if (busOff) begin
          if (bom_reg == BOM_AT_ENTRY && busOffEntry) state_next = ST_HALT; // [RULE_06]
          else if (bom_reg == BOM_AT_END && recoveryDone) state_next = ST_HALT; // [RULE_07]
          else if (bom_reg == BOM_ON_REQ && haltAsk) state_next = ST_HALT; // [RULE_08]
          else if (bom_reg == BOM_DEFAULT && haltAsk && recoveryDone)
            state_next = ST_HALT; // [RULE_05]
        end else if (haltAsk) begin
          if (!(receiving || transmitting) || msgDone) state_next = ST_HALT; // [RULE_04]
        end
      end
      ST_RESET, ST_HALT: begin
        if (mode_reg == MODE_FORCE || (mode_reg == MODE_RESET)) state_next = ST_RESET;
        else if (mode_reg == MODE_OPER && !haltReq_reg) state_next = ST_OPER;
        else if (mode_reg == MODE_HALT && state_reg == ST_RESET) state_next = ST_HALT;
      end
      ST_INTRST: begin
        // Short internal reset, then back to operation
        if (hold_reg == 2'h0) state_next = ST_OPER; // [RULE_11]
        else hold_next = hold_reg - 2'h1;
      end
      default: state_next = ST_RESET;
    endcase
  end

  assign events = {state_next == ST_HALT && state_reg != ST_HALT,
                   state_next == ST_RESET && state_reg != ST_RESET,
                   unlockPulse, busOffEntry};
  irq_status #(.WIDTH(IRQ_W)) irqStat (
    .clock(clock),
    .resetn(resetn),
    .enable(clockEnable),
    .events(events),
    .clearMask(clrMask),
    .irqEnable(irqEn_reg),
    .status(status),
    .irq(irq)
  );

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= ST_RESET;
      hold_reg <= '0;
      busOffDly_reg <= 1'b0;
      mode_reg <= MODE_RESET;
      bom_reg <= BOM_DEFAULT;
      haltReq_reg <= 1'b0;
      clkSel_reg <= 1'b0;
      irqEn_reg <= '0;
      rxPtr_reg <= '0;
      txPtr_reg <= '0;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      b_reg <= 1'b0;
      r_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      bresp_reg <= RESP_OKAY;
    end else if (clockEnable) begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      busOffDly_reg <= busOff;
      mode_reg <= mode_next;
      bom_reg <= bom_next;
      haltReq_reg <= haltReq_next;
      clkSel_reg <= clkSel_next;
      irqEn_reg <= irqEn_next;
      rxPtr_reg <= rxPtr_next;
      txPtr_reg <= txPtr_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      b_reg <= b_next;
      r_reg <= r_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_bvalid = b_reg && clockEnable;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = r_reg && clockEnable;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign channelState = state_reg;
  assign clockSource = clkSel_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !clockEnable);
  sequence s_oper_force;
    state_reg == ST_OPER && mode_reg == MODE_FORCE && !unlockPulse;
  endsequence
  a_force_reset: assert property (s_oper_force |=> state_reg == ST_RESET) // [RULE_01]
    else $error("forcible reset not immediate");
  a_tx_waits: assert property (state_reg == ST_OPER && mode_reg == MODE_RESET && transmitting
    && !txEnd && !busOff && !txSuspended |=> state_reg != ST_RESET) // [RULE_02]
    else $error("reset entered mid transmission");
  a_busoff_reset: assert property (state_reg == ST_OPER && mode_reg == MODE_RESET && busOff
    && !unlockPulse |=> state_reg == ST_RESET) // [RULE_03]
    else $error("reset waited for recovery");
  a_halt_waits: assert property (state_reg == ST_OPER && mode_reg == MODE_HALT && !busOff
    && receiving && !rxEnd && !transmitting |=> state_reg != ST_HALT) // [RULE_04]
    else $error("halt entered mid reception");
  a_bom_default: assert property (state_reg == ST_OPER && busOff && bom_reg == BOM_DEFAULT
    && !recoveryDone && mode_reg == MODE_OPER |=> state_reg != ST_HALT) // [RULE_05]
    else $error("halt before recovery");
  a_bom_entry: assert property (state_reg == ST_OPER && mode_reg == MODE_OPER && busOffEntry
    && bom_reg == BOM_AT_ENTRY && !unlockPulse |=> state_reg == ST_HALT) // [RULE_06]
    else $error("no halt on bus-off entry");
  a_bom_end: assert property (state_reg == ST_OPER && mode_reg == MODE_OPER && busOff
    && recoveryDone && bom_reg == BOM_AT_END && !unlockPulse |=> state_reg == ST_HALT) // [RULE_07]
    else $error("no halt after recovery");
  a_bom_req: assert property (state_reg == ST_OPER && mode_reg == MODE_OPER && busOff
    && haltReq_reg && bom_reg == BOM_ON_REQ && !unlockPulse |=> state_reg == ST_HALT) // [RULE_08]
    else $error("halt request ignored in bus-off");
  a_suspend_idle: assert property (state_reg == ST_OPER && mode_reg == MODE_RESET && txSuspended
    && busIdle && !unlockPulse |=> state_reg == ST_RESET) // [RULE_09]
    else $error("suspended reset not completed");
  a_intrst_path: assert property (state_reg == ST_OPER && unlockPulse
    |=> state_reg == ST_INTRST ##3 state_reg == ST_OPER) // [RULE_11]
    else $error("internal reset sequence broken");
endmodule : can_mode_transition_control

// ==== can_mode_pkg.sv ====
package can_mode_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_RXFPC = 8'h0c;
  localparam logic [7:0] ADDR_TXFPC = 8'h10;
  localparam logic [7:0] ADDR_ERRCAUSE = 8'h14;
  localparam logic [7:0] ADDR_IRQEN = 8'h18;
  localparam logic [7:0] ADDR_IRQCLR = 8'h1c;
  localparam logic [7:0] ADDR_FIFOPTR = 8'h20;
  localparam int MODE_LSB = 0;
  localparam int BOM_LSB = 2;
  localparam int HALTREQ_BIT = 4;
  localparam int CLKSEL_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam logic [1:0] MODE_OPER = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_HALT = 2'h2;
  localparam logic [1:0] MODE_FORCE = 2'h3;
  localparam logic [1:0] BOM_DEFAULT = 2'h0;
  localparam logic [1:0] BOM_AT_ENTRY = 2'h1;
  localparam logic [1:0] BOM_AT_END = 2'h2;
  localparam logic [1:0] BOM_ON_REQ = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam int IRQ_RESET = 2;
  localparam int IRQ_HALT = 3;
  localparam int IRQ_W = 4;
  localparam int LOCK_TIME_NS = 275000;
  localparam int CLOCK_NS = 25;
  localparam int LOCK_CYCLES = LOCK_TIME_NS / CLOCK_NS;
  localparam int RESET_HOLD_CYCLES = 2;
  typedef enum logic [3:0] {
    ST_OPER = 4'h1,
    ST_RESET = 4'h2,
    ST_HALT = 4'h4,
    ST_INTRST = 4'h8
  } chan_state_t;
endpackage : can_mode_pkg

// ==== bus_lock_detect.sv ====
`timescale 1ns/1ps
module bus_lock_detect #(
  parameter int LOCK_LEN = 11000
) (
  // Clocking
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  // Bus level, 0 is dominant
  input wire logic busLevel,
  // Results
  output logic locked,
  output logic unlockPulse
);
  logic [31:0] count_reg, count_next;
  logic locked_reg, locked_next;
  always_comb begin
    count_next = count_reg;
    locked_next = locked_reg;
    if (busLevel) begin
      count_next = '0;
      locked_next = 1'b0; // Recessive bit ends the lock [RULE_12]
    end else if (count_reg < 32'(LOCK_LEN)) begin
      count_next = count_reg + 32'h1;
    end else begin
      locked_next = 1'b1; // [RULE_10]
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count_reg <= '0;
      locked_reg <= 1'b0;
    end else if (enable) begin
      count_reg <= count_next;
      locked_reg <= locked_next;
    end
  end
  assign locked = locked_reg;
  assign unlockPulse = enable && locked_reg && !locked_next;
  a_lock_clears: assert property (@(posedge clock) disable iff (!resetn)
    enable && busLevel |=> !locked) // [RULE_12]
    else $error("lock flag survived a recessive bit");
  a_lock_sets: assert property (@(posedge clock) disable iff (!resetn)
    (count_reg >= 32'(LOCK_LEN)) && enable && !busLevel |=> locked) // [RULE_10]
    else $error("lock flag not raised");
endmodule : bus_lock_detect

// ==== irq_status.sv ====
`timescale 1ns/1ps
module irq_status #(
  parameter int WIDTH = 4
) (
  // Clocking
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  // Events and software
  input wire logic [WIDTH-1:0] events,
  input wire logic [WIDTH-1:0] clearMask,
  input wire logic [WIDTH-1:0] irqEnable,
  // Results
  output logic [WIDTH-1:0] status,
  output logic irq
);
  logic [WIDTH-1:0] status_reg, status_next;
  always_comb begin
    status_next = status_reg;
    for (int i = 0; i < WIDTH; i++) begin
      // Set beats clear in the same cycle
      if (events[i]) status_next[i] = 1'b1;
      else if (clearMask[i]) status_next[i] = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) status_reg <= '0;
    else if (enable) status_reg <= status_next;
  end
  assign status = status_reg;
  assign irq = |(status_reg & irqEnable);
  a_set_wins: assert property (@(posedge clock) disable iff (!resetn)
    enable && events[0] && clearMask[0] |=> status[0])
    else $error("event lost against clear");
endmodule : irq_status

// ==== can_far_side.sv ====
`timescale 1ns/1ps
module can_far_side (
  // Clocking
  input wire logic clock,
  // Engine levels seen by the channel
  output logic receiving,
  output logic transmitting,
  output logic txSuspended,
  output logic busIdle,
  output logic busOff,
  output logic busLevel,
  // Engine pulses
  output logic txEnd,
  output logic rxEnd,
  output logic recoveryDone
);
  initial begin
    receiving = 1'b0;
    transmitting = 1'b0;
    txSuspended = 1'b0;
    busIdle = 1'b1;
    busOff = 1'b0;
    busLevel = 1'b1;
    txEnd = 1'b0;
    rxEnd = 1'b0;
    recoveryDone = 1'b0;
  end

  task automatic activity(input logic rx, input logic tx, input logic susp);
    receiving <= rx;
    transmitting <= tx;
    txSuspended <= susp;
    busIdle <= !(rx | tx | susp);
  endtask : activity

  // End pulse lasts exactly one cycle, as a real engine gives it
  task automatic finish_frame();
    txEnd <= transmitting;
    rxEnd <= receiving;
    receiving <= 1'b0;
    transmitting <= 1'b0;
    busIdle <= 1'b1;
    @(posedge clock);
    txEnd <= 1'b0;
    rxEnd <= 1'b0;
  endtask : finish_frame

  task automatic bus_off(input logic v);
    busOff <= v;
  endtask : bus_off

  // Bus-off lifts only once the recovery pulse has been seen
  task automatic recover();
    recoveryDone <= 1'b1;
    @(posedge clock);
    recoveryDone <= 1'b0;
    busOff <= 1'b0;
  endtask : recover

  // Bus goes idle while a transmission stays suspended
  task automatic go_idle();
    busIdle <= 1'b1;
  endtask : go_idle

  // Stuck dominant models a shorted bus; recessive is the released level
  task automatic dominant(input logic v);
    busLevel <= !v;
  endtask : dominant
endmodule : can_far_side

// ==== can_mode_transition_control_tb_top.sv ====
`timescale 1ns/1ps
module can_mode_transition_control_tb_top;
  import can_mode_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clockEnable = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] channelState;
  logic clockSource, rxPtrAdvance, txPtrAdvance, irq;
  logic receiving, transmitting, txSuspended, busIdle, busOff, busLevel;
  logic txEnd, rxEnd, recoveryDone;
  int n_fail = 0;
  int checked = 0;
  int nRx = 0;
  int nTx = 0;

  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (rxPtrAdvance === 1'b1) nRx++;
    if (txPtrAdvance === 1'b1) nTx++;
  end

  can_far_side u_far (.clock(clock), .receiving(receiving), .transmitting(transmitting),
    .txSuspended(txSuspended), .busIdle(busIdle), .busOff(busOff), .busLevel(busLevel),
    .txEnd(txEnd), .rxEnd(rxEnd), .recoveryDone(recoveryDone));

  // Short lock count keeps the stuck-bus run brief
  can_mode_transition_control #(.LOCK_LEN(8)) u_dut (.clock(clock), .resetn(resetn),
    .clockEnable(clockEnable), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .receiving(receiving), .transmitting(transmitting), .txSuspended(txSuspended),
    .busIdle(busIdle), .txEnd(txEnd), .rxEnd(rxEnd), .busOff(busOff),
    .recoveryDone(recoveryDone), .busLevel(busLevel), .channelState(channelState),
    .clockSource(clockSource), .rxPtrAdvance(rxPtrAdvance), .txPtrAdvance(txPtrAdvance),
    .irq(irq));

  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic timeout();
    n_fail++;
    $display("Wait ran out at %0t", $time);
    tally_and_finish();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (n == 40) timeout();
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (n == 40) timeout();
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  function automatic logic [31:0] ctrl(input logic [1:0] busoff_recovery_field, input logic [1:0] mode);
    return {28'h0, busoff_recovery_field, mode};
  endfunction : ctrl

  task automatic wait_state(input logic [3:0] exp);
    int n;
    for (n = 0; n < 30; n++) begin
      @(posedge clock);
      if (channelState === exp) break;
    end
    check({28'h0, channelState}, {28'h0, exp});
    if (n == 30) timeout();
  endtask : wait_state

  // Fixed wait only proves that nothing moved while the cause is absent
  task automatic hold(input logic [3:0] exp);
    repeat (6) @(posedge clock);
    check({28'h0, channelState}, {28'h0, exp});
  endtask : hold

  task automatic to_oper();
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_RESET));
    wait_state(ST_RESET);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_OPER));
    wait_state(ST_OPER);
  endtask : to_oper

  task automatic t_reset_regs();
    check({28'h0, channelState}, {28'h0, ST_RESET});
    axi_read(ADDR_ERRCAUSE);
    check(rd & 32'h1, 32'h0);
    axi_read(8'h40);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_OPER));
    wait_state(ST_OPER);
  endtask : t_reset_regs

  task automatic t_clksel_fifo();
    axi_write(ADDR_CLKSEL, 32'hff);
    axi_read(ADDR_CLKSEL);
    check(rd, 32'h1);
    check({31'h0, clockSource}, 32'h1);
    axi_write(ADDR_CLKSEL, 32'hfe);
    axi_read(ADDR_CLKSEL);
    check(rd, 32'h0);
    axi_write(ADDR_RXFPC, 32'hff);
    check(nRx, 1);
    check(nTx, 0);
    axi_write(ADDR_TXFPC, 32'hff);
    check(nTx, 1);
    axi_read(ADDR_TXFPC);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_read(ADDR_FIFOPTR);
    check(rd, 32'h0101);
  endtask : t_clksel_fifo

  // Stuck bus while frozen must not count towards a lock
  task automatic t_freeze();
    clockEnable <= 1'b0;
    u_far.dominant(1'b1);
    repeat (20) @(posedge clock);
    check({28'h0, channelState}, {28'h0, ST_OPER});
    check({31'h0, s_axi_awready}, 32'h0);
    u_far.dominant(1'b0);
    @(posedge clock);
    clockEnable <= 1'b1;
    axi_read(ADDR_ERRCAUSE);
    check(rd & 32'h1, 32'h0);
  endtask : t_freeze

  task automatic t_reset_modes();
    u_far.activity(1'b0, 1'b1, 1'b0);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_FORCE));
    wait_state(ST_RESET);
    u_far.activity(1'b0, 1'b0, 1'b0);
    to_oper();
    u_far.activity(1'b1, 1'b0, 1'b0);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_RESET));
    wait_state(ST_RESET);
    u_far.activity(1'b0, 1'b1, 1'b0);
    to_oper();
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_RESET));
    hold(ST_OPER);
    u_far.finish_frame();
    wait_state(ST_RESET);
    to_oper();
    u_far.activity(1'b0, 1'b0, 1'b1);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_RESET));
    hold(ST_OPER);
    u_far.go_idle();
    wait_state(ST_RESET);
    u_far.activity(1'b0, 1'b0, 1'b0);
    to_oper();
  endtask : t_reset_modes

  task automatic t_halt();
    u_far.activity(1'b1, 1'b0, 1'b0);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_HALT));
    hold(ST_OPER);
    u_far.finish_frame();
    wait_state(ST_HALT);
    to_oper();
  endtask : t_halt

  task automatic t_busoff();
    axi_write(ADDR_CTRL, ctrl(BOM_AT_ENTRY, MODE_OPER));
    u_far.bus_off(1'b1);
    wait_state(ST_HALT);
    u_far.bus_off(1'b0);
    to_oper();
    axi_write(ADDR_CTRL, ctrl(BOM_AT_END, MODE_OPER));
    u_far.bus_off(1'b1);
    hold(ST_OPER);
    u_far.recover();
    wait_state(ST_HALT);
    to_oper();
    axi_write(ADDR_CTRL, ctrl(BOM_ON_REQ, MODE_OPER));
    u_far.bus_off(1'b1);
    hold(ST_OPER);
    axi_write(ADDR_CTRL, ctrl(BOM_ON_REQ, MODE_OPER) | (32'h1 << HALTREQ_BIT));
    wait_state(ST_HALT);
    u_far.bus_off(1'b0);
    to_oper();
    u_far.bus_off(1'b1);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_HALT));
    hold(ST_OPER);
    u_far.recover();
    wait_state(ST_HALT);
    to_oper();
    u_far.bus_off(1'b1);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_FORCE));
    wait_state(ST_RESET);
    to_oper();
    u_far.bus_off(1'b1);
    axi_write(ADDR_CTRL, ctrl(BOM_DEFAULT, MODE_RESET));
    wait_state(ST_RESET);
    u_far.bus_off(1'b0);
    to_oper();
  endtask : t_busoff

  task automatic t_lock_irq();
    axi_write(ADDR_IRQCLR, 32'hf);
    u_far.dominant(1'b1);
    repeat (20) @(posedge clock);
    axi_read(ADDR_ERRCAUSE);
    check(rd & 32'h1, 32'h1);
    u_far.dominant(1'b0);
    wait_state(ST_INTRST);
    wait_state(ST_OPER);
    axi_read(ADDR_ERRCAUSE);
    check(rd & 32'h1, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    axi_write(ADDR_IRQEN, 32'h1 << IRQ_UNLOCK);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    axi_write(ADDR_IRQCLR, 32'h1 << IRQ_UNLOCK);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
  endtask : t_lock_irq

  initial begin
    #1500000;
    timeout();
  end

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset_regs();
    t_clksel_fifo();
    t_freeze();
    t_reset_modes();
    t_halt();
    t_busoff();
    t_lock_irq();
    tally_and_finish();
  end
endmodule : can_mode_transition_control_tb_top
